// ==== src/tws_pkg.sv ====
package tws_pkg;
   // ----------------------------------------
   // word classes
   // ----------------------------------------
   localparam logic [1:0] TWS_KIND_DATA = 2'h0;
   localparam logic [1:0] TWS_KIND_CMD = 2'h1;
   localparam logic [1:0] TWS_KIND_ADDR = 2'h2;
   // ----------------------------------------
   // sizes and timing
   // ----------------------------------------
   localparam int TWS_WORD_BITS = 8;
   localparam logic [3:0] TWS_BIT_LAST = 4'h8;
   localparam logic [3:0] TWS_BIT_ACK = 4'h9;
   localparam int TWS_CLK_MHZ = 40;
   localparam int TWS_ACK_TIMEOUT_US = 100;
   localparam int TWS_ACK_TIMEOUT_CYC = TWS_ACK_TIMEOUT_US * TWS_CLK_MHZ;
   localparam logic [7:0] TWS_ADDR_RST = 8'h00;
   typedef enum logic [3:0] {
      TWS_ST_IDLE = 4'h1,
      TWS_ST_SHIFT = 4'h2,
      TWS_ST_ACK = 4'h4,
      TWS_ST_BUSY = 4'h8
   } tws_state_t;
endpackage

// ==== src/tws_slave.sv ====
`timescale 1ns/10ps
module tws_slave (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sck_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic irq_out
);
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] A_SHIFT = 4'h0;
   localparam logic [3:0] A_SVA = 4'h1;
   localparam logic [3:0] A_CTRL = 4'h2;
   localparam logic [3:0] A_STAT = 4'h3;
   localparam logic [3:0] A_TRIG = 4'h4;
   localparam int C_EN = 0;
   localparam int C_WUP = 1;
   localparam int C_AUTO_ACK_ENABLE = 2;
   localparam int T_ACK = 0;
   localparam int T_BUSY_REL = 1;
   localparam int T_BUSY_SET = 2;
   localparam int T_IRQ_CLR = 3;
   localparam logic [15:0] TO_CYC = 16'(tws_pkg::TWS_ACK_TIMEOUT_CYC);

   // ----------------------------------------
   // line sampling and edges
   // ----------------------------------------
   logic sck_s, sda_s, sck_d_ff, sda_d_ff;
   tws_sync u_sck (.clk_in(clk_in), .rst_n_in(rst_n_in), .d_in(sck_in), .q_out(sck_s));
   tws_sync u_sda (.clk_in(clk_in), .rst_n_in(rst_n_in), .d_in(sda_in), .q_out(sda_s));
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         sck_d_ff <= sck_s;
         sda_d_ff <= sda_s;
      end
   end
   logic sck_rise, sck_fall, rel_det, cmd_det;
   assign sck_rise = sck_s && !sck_d_ff;
   assign sck_fall = !sck_s && sck_d_ff;
   // conditions only count while clock rests high
   assign rel_det = sck_s && sck_d_ff && sda_s && !sda_d_ff;
   assign cmd_det = sck_s && sck_d_ff && !sda_s && sda_d_ff;

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   logic [7:0] sva_ff, shift_ff;
   logic [2:0] ctrl_ff;
   logic en, wakeup_enable, auto_ack_enable;
   assign en = ctrl_ff[C_EN];
   assign wakeup_enable = ctrl_ff[C_WUP];
   assign auto_ack_enable = ctrl_ff[C_AUTO_ACK_ENABLE];
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sva_ff <= tws_pkg::TWS_ADDR_RST;
         ctrl_ff <= 3'h0;
      end else if (wr_in && addr_in == A_SVA) begin
         sva_ff <= wdata_in;
      end else if (wr_in && addr_in == A_CTRL) begin
         ctrl_ff <= wdata_in[2:0]; // wake-up set or cleared by software
      end
   end

   // ----------------------------------------
   // transfer state machine
   // ----------------------------------------
   tws_pkg::tws_state_t state_ff;
   logic [3:0] bit_ff;
   logic release_detected_flag_ff, cmdd_ff, sel_ff, ackt_ff, busy_ff, busy_req_ff, ack_drv_ff;
   logic ackd_ff, irq_ff, match_ff, to_ff;
   logic [1:0] kind_ff;
   logic [15:0] to_cnt_ff;
   logic start_wr, word_done, match;
   assign start_wr = wr_in && addr_in == A_SHIFT && en;
   assign word_done = sck_rise && state_ff == tws_pkg::TWS_ST_SHIFT && bit_ff == 4'h7;
   assign match = {shift_ff[6:0], sda_s} == sva_ff;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= tws_pkg::TWS_ST_IDLE;
         bit_ff <= 4'h0;
      end else if (!en || rel_det || cmd_det) begin
         state_ff <= tws_pkg::TWS_ST_IDLE;
         bit_ff <= 4'h0;
      end else if (start_wr && state_ff != tws_pkg::TWS_ST_SHIFT) begin
         // a write after an ended word restarts at once
         state_ff <= tws_pkg::TWS_ST_SHIFT;
         bit_ff <= 4'h0;
      end else begin
         case (state_ff)
            tws_pkg::TWS_ST_IDLE: begin
               // falling clock starts a word unless busy is held or pending
               if ((sck_fall && !busy_req_ff && !busy_ff) || start_wr) begin
                  state_ff <= tws_pkg::TWS_ST_SHIFT;
                  bit_ff <= 4'h0;
               end
            end
            tws_pkg::TWS_ST_SHIFT: begin
               if (sck_rise) begin
                  bit_ff <= bit_ff + 4'h1;
               end
               if (word_done) begin
                  state_ff <= tws_pkg::TWS_ST_ACK;
               end
            end
            tws_pkg::TWS_ST_ACK: begin
               if (sck_rise) begin
                  bit_ff <= bit_ff + 4'h1;
               end
               if (sck_fall && bit_ff >= tws_pkg::TWS_BIT_ACK) begin
                  state_ff <= tws_pkg::TWS_ST_BUSY;
               end
            end
            tws_pkg::TWS_ST_BUSY: begin
               // ready seen on a high clock: the master stops clocking here
               if (sck_rise && !busy_ff && !busy_req_ff) begin
                  state_ff <= tws_pkg::TWS_ST_IDLE;
               end
            end
            default: state_ff <= tws_pkg::TWS_ST_IDLE;
         endcase
      end
   end

   // receive shift: sample on rising clock, msb first
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_ff <= 8'h00;
      end else if (wr_in && addr_in == A_SHIFT) begin
         shift_ff <= wdata_in;
      end else if (sck_rise && state_ff == tws_pkg::TWS_ST_SHIFT) begin
         shift_ff <= {shift_ff[6:0], sda_s};
      end
   end

   // release and command flags; a set wins over a clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         release_detected_flag_ff <= 1'b0;
         cmdd_ff <= 1'b0;
      end else begin
         if (rel_det) begin
            release_detected_flag_ff <= 1'b1;
         end else if (!en || start_wr || (word_done && kind_ff == tws_pkg::TWS_KIND_ADDR
                     && !match)) begin
            release_detected_flag_ff <= 1'b0;
         end
         if (cmd_det) begin
            cmdd_ff <= 1'b1;
         end else if (!en || start_wr || rel_det) begin
            cmdd_ff <= 1'b0;
         end
      end
   end
   // word class from flags at word end
   always_comb begin
      if (release_detected_flag_ff && cmdd_ff) begin
         kind_ff = tws_pkg::TWS_KIND_ADDR;
      end else if (cmdd_ff) begin
         kind_ff = tws_pkg::TWS_KIND_CMD;
      end else begin
         kind_ff = tws_pkg::TWS_KIND_DATA;
      end
   end

   // selection and address comparator
   logic [1:0] last_kind_ff;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_ff <= 1'b0;
         match_ff <= 1'b0;
         last_kind_ff <= tws_pkg::TWS_KIND_DATA;
      end else if (!en) begin
         sel_ff <= 1'b0;
      end else if (word_done) begin
         last_kind_ff <= kind_ff;
         match_ff <= match;
         if (kind_ff == tws_pkg::TWS_KIND_ADDR) begin
            sel_ff <= match; // held until next address or disable
         end
      end
   end

   // interrupt: every word, or only matching address under wake-up
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_ff <= 1'b0;
      end else if (word_done && (!wakeup_enable || (kind_ff == tws_pkg::TWS_KIND_ADDR && match))) begin
         irq_ff <= 1'b1;
      end else if (wr_in && addr_in == A_TRIG && wdata_in[T_IRQ_CLR]) begin
         irq_ff <= 1'b0;
      end
   end
   assign irq_out = irq_ff;

   // acknowledge trigger, busy and ack detect
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ackt_ff <= 1'b0;
         ack_drv_ff <= 1'b0;
         ackd_ff <= 1'b0;
         busy_req_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         if (wr_in && addr_in == A_TRIG && wdata_in[T_ACK]) begin
            ackt_ff <= 1'b1;
         end else if (ack_drv_ff && sck_fall) begin
            ackt_ff <= 1'b0;
         end
         if (wr_in && addr_in == A_TRIG && wdata_in[T_BUSY_SET]) begin
            busy_req_ff <= 1'b1;
         end else if (wr_in && addr_in == A_TRIG && wdata_in[T_BUSY_REL]) begin
            busy_req_ff <= 1'b0;
         end
         // one-shot ack for one clock period from a falling edge
         if (sck_fall) begin
            ack_drv_ff <= state_ff == tws_pkg::TWS_ST_ACK && !ack_drv_ff &&
                          ((auto_ack_enable && bit_ff == tws_pkg::TWS_BIT_LAST) || ackt_ff);
            busy_ff <= busy_req_ff && (state_ff != tws_pkg::TWS_ST_SHIFT);
         end
         if (sck_rise && state_ff == tws_pkg::TWS_ST_ACK && !sda_s) begin
            ackd_ff <= 1'b1; // returned ack seen
         end else if (start_wr) begin
            ackd_ff <= 1'b0;
         end
      end
   end

   // ack timeout after sending a word
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         to_cnt_ff <= 16'h0000;
         to_ff <= 1'b0;
      end else if (start_wr) begin
         to_cnt_ff <= 16'h0000;
         to_ff <= 1'b0;
      end else if (state_ff == tws_pkg::TWS_ST_ACK && !ackd_ff && !to_ff) begin
         to_cnt_ff <= to_cnt_ff + 16'h0001;
         if (to_cnt_ff == TO_CYC) begin
            to_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // open-drain data output
   // ----------------------------------------
   logic tx_low, tx_bit_low;
   assign tx_bit_low = state_ff == tws_pkg::TWS_ST_SHIFT && !shift_ff[7] && sel_ff;
   // wake-up keeps the line released until selected
   assign tx_low = (!wakeup_enable || sel_ff) && (tx_bit_low || ack_drv_ff || busy_ff);
   assign sda_out = 1'b0; // only ever pulls low
   assign sda_oe_out = en && tx_low;

   // read port, data one cycle later
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            A_SHIFT: rdata_out <= shift_ff;
            A_SVA: rdata_out <= sva_ff;
            A_CTRL: rdata_out <= {5'h00, ctrl_ff};
            A_STAT: rdata_out <= {last_kind_ff, to_ff, ackd_ff, irq_ff, match_ff,
                                  cmdd_ff, release_detected_flag_ff};
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_rel_flag;
      @(posedge clk_in) disable iff (!rst_n_in) rel_det |=> release_detected_flag_ff;
   endproperty
   a_rel_flag: assert property (p_rel_flag) else $error("release flag not set");
   property p_od;
      @(posedge clk_in) disable iff (!rst_n_in) sda_oe_out |-> !sda_out;
   endproperty
   a_od: assert property (p_od) else $error("data line driven high");
   property p_wake;
      @(posedge clk_in) disable iff (!rst_n_in) (wakeup_enable && !sel_ff) |-> !sda_oe_out;
   endproperty
   a_wake: assert property (p_wake) else $error("drive while unselected");
   property p_irq_wup;
      @(posedge clk_in) disable iff (!rst_n_in)
         (wakeup_enable && word_done && kind_ff != tws_pkg::TWS_KIND_ADDR && !irq_ff) |=> !irq_ff;
   endproperty
   a_irq_wup: assert property (p_irq_wup) else $error("irq without address");
   property p_busy_fall;
      @(posedge clk_in) disable iff (!rst_n_in) $changed(busy_ff) |-> $past(sck_fall);
   endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy off falling edge");
   property p_ack_fall;
      @(posedge clk_in) disable iff (!rst_n_in) $rose(ack_drv_ff) |-> $past(sck_fall);
   endproperty
   a_ack_fall: assert property (p_ack_fall) else $error("ack off falling edge");
   property p_sel;
      @(posedge clk_in) disable iff (!rst_n_in)
         (word_done && kind_ff == tws_pkg::TWS_KIND_ADDR && en) |=> sel_ff == $past(match);
   endproperty
   a_sel: assert property (p_sel) else $error("selection wrong");
   property p_cmd_cond;
      @(posedge clk_in) disable iff (!rst_n_in) cmd_det |-> sck_s && sck_d_ff;
   endproperty
   a_cmd_cond: assert property (p_cmd_cond) else $error("command with clock low");
   c_addr: cover property (@(posedge clk_in) word_done && kind_ff == tws_pkg::TWS_KIND_ADDR);
   c_ack: cover property (@(posedge clk_in) $rose(ack_drv_ff));
   c_busy: cover property (@(posedge clk_in) $fell(busy_ff));
endmodule

// ==== src/tws_sync.sv ====
`timescale 1ns/10ps
// two-flop synchroniser for pin levels
module tws_sync (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_ff;
   // first flop feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_ff <= 1'b1;
         q_out <= 1'b1;
      end else begin
         meta_ff <= d_in;
         q_out <= meta_ff;
      end
   end
endmodule

// ==== testbench/tws_master_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// bus master stand-in
// ----------------------------------------
// clock line rests high between frames; data pulled low only, never driven high
module tws_master_model (
   input wire logic sda_in,
   output logic sck_out,
   output logic sda_oe_out
);
   localparam time HALF = 100;
   initial begin
      sck_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // data rises while clock rests high
   task automatic rel_cond();
      sda_oe_out = 1'b1;
      #HALF;
      sda_oe_out = 1'b0;
      #HALF;
   endtask
   // data falls while clock rests high
   task automatic cmd_cond();
      sda_oe_out = 1'b0;
      #HALF;
      sda_oe_out = 1'b1;
      #HALF;
   endtask
   // eight bits msb first, then a ninth clock that listens for acknowledge
   task automatic send_byte(input logic [7:0] b, output logic ack);
      ack = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sck_out = 1'b0;
         sda_oe_out = ~b[i];
         #HALF;
         sck_out = 1'b1;
         #HALF;
      end
      sck_out = 1'b0;
      sda_oe_out = 1'b0; // released on a low clock so no condition is faked
      #HALF;
      ack = ack | ~sda_in;
      sck_out = 1'b1;
      #(HALF / 2);
      ack = ack | ~sda_in;
      #(HALF / 2);
   endtask
   // a single clock pulse, lets the slave set busy on its fall
   task automatic one_clock();
      sck_out = 1'b0;
      #HALF;
      sck_out = 1'b1;
      #HALF;
   endtask
   // clock on while the slave holds busy, stop on ready; bounded wait
   task automatic clock_until_ready(output logic [7:0] n);
      n = 8'h00;
      while (sda_in === 1'b0 && n < 8'h40) begin
         sck_out = 1'b0;
         #HALF;
         sck_out = 1'b1;
         #HALF;
         n++;
      end
   endtask
endmodule

// ==== testbench/tws_slave_bench.sv ====
`timescale 1ns/10ps
module tws_slave_bench;
   logic clk_in, rst_n_in, sck, m_oe, sda_out, sda_oe_out, wr_in, rd_in, irq_out, ack, oe_seen;
   logic [3:0] addr_in;
   logic [7:0] wdata_in, rdata_out, d, sa, n;
   int failures = 0;
   int total_checks = 0;
   int oe_cnt;
   // wired line with pull-up: low if anyone pulls
   wire logic sda_w = !(m_oe || (sda_oe_out && !sda_out));
   tws_slave i_tws_slave (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
   tws_master_model i_tws_master_model (.sda_in(sda_w), .sck_out(sck), .sda_oe_out(m_oe));
   // ----------------------------------------
   // clock, monitor, helpers
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // count cycles the slave pulls the line; open drain must output zero
   always @(posedge clk_in) begin
      if (sda_oe_out === 1'b1) begin
         oe_cnt++;
         oe_seen = 1'b1;
         if (sda_out !== 1'b0) oe_seen = 1'bx;
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
   endtask
   task automatic settle();
      repeat (6) @(posedge clk_in);
   endtask
   // expected word class from the conditions that preceded it
   function automatic logic [1:0] exp_kind(input logic bus_release_condition, input logic cmd);
      if (bus_release_condition && cmd) return tws_pkg::TWS_KIND_ADDR;
      if (cmd) return tws_pkg::TWS_KIND_CMD;
      return tws_pkg::TWS_KIND_DATA;
   endfunction
   // ----------------------------------------
   // watchdog and main sequence
   // ----------------------------------------
   initial begin
      #400000;
      failures++;
      conclude();
   end
   initial begin
      rst_n_in = 1'b0;
      {wr_in, rd_in, addr_in, wdata_in, oe_seen, oe_cnt} = '0;
      void'($urandom(32'hbac3cd98));
      sa = $urandom();
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(4'h3, d);
      chk("status_rst", d, 8'h00);
      chk("irq_rst", {7'h0, irq_out}, 8'h00);
      wr(4'h1, sa);
      wr(4'h2, 8'h03);
      wr(4'hF, 8'hA5);
      rd(4'h1, d);
      chk("slave_addr", d, sa);
      rd(4'hF, d);
      chk("unmapped", d, 8'h00);
      // wake-up on: foreign address ignored, line untouched
      i_tws_master_model.rel_cond();
      settle();
      rd(4'h3, d);
      chk("release_detected_flag_set", {7'h0, d[0]}, 8'h01);
      i_tws_master_model.cmd_cond();
      i_tws_master_model.send_byte(sa ^ 8'h01, ack);
      settle();
      rd(4'h3, d);
      chk("release_detected_flag_clr", {6'h0, d[2], d[0]}, 8'h00);
      chk("irq_miss", {7'h0, irq_out}, 8'h00);
      chk("hiz_wake", {7'h0, oe_seen}, 8'h00);
      i_tws_master_model.rel_cond();
      i_tws_master_model.cmd_cond();
      i_tws_master_model.send_byte(sa, ack);
      settle();
      chk("irq_hit", {7'h0, irq_out}, 8'h01);
      rd(4'h3, d);
      chk("kind_addr", {6'h0, d[7:6]}, {6'h0, exp_kind(1'b1, 1'b1)});
      chk("match", {7'h0, d[2]}, 8'h01);
      rd(4'h0, d);
      chk("addr_word", d, sa);
      wr(4'h4, 8'h08);
      settle();
      chk("irq_clr", {7'h0, irq_out}, 8'h00);
      // wake-up off: command word, then plain data, each raises irq
      wr(4'h2, 8'h01);
      for (int k = 1; k >= 0; k--) begin
         wr(4'h0, 8'hFF);
         if (k == 1) i_tws_master_model.cmd_cond();
         n = $urandom();
         i_tws_master_model.send_byte(n, ack);
         settle();
         rd(4'h3, d);
         chk("kind", {6'h0, d[7:6]}, {6'h0, exp_kind(1'b0, k[0])});
         rd(4'h0, d);
         chk("word", d, n);
         chk("no_ack", {7'h0, ack}, 8'h00);
         chk("irq_word", {7'h0, irq_out}, 8'h01);
         wr(4'h4, 8'h08);
      end
      // automatic acknowledge on the ninth clock, a single short pulse
      wr(4'h2, 8'h05);
      wr(4'h0, 8'hFF);
      settle();
      oe_cnt = 0;
      i_tws_master_model.send_byte($urandom(), ack);
      i_tws_master_model.clock_until_ready(n);
      chk("ack_end", n, 8'h01);
      settle();
      chk("auto_ack", {7'h0, ack}, 8'h01);
      chk("ack_pulse", {7'h0, oe_cnt > 0 && oe_cnt <= 8}, 8'h01);
      // busy: waits for a clock fall to set and to release
      wr(4'h2, 8'h01);
      wr(4'h4, 8'h04);
      settle();
      chk("busy_wait", {7'h0, sda_oe_out}, 8'h00);
      i_tws_master_model.one_clock();
      i_tws_master_model.clock_until_ready(n);
      chk("busy_low", {7'h0, sda_w}, 8'h00);
      wr(4'h4, 8'h02);
      settle();
      chk("busy_hold", {7'h0, sda_oe_out}, 8'h01);
      i_tws_master_model.clock_until_ready(n);
      chk("ready_falls", n, 8'h01);
      chk("open_drain", {7'h0, oe_seen}, 8'h01);
      conclude();
   end
endmodule
